// ---- src/iwfd_pkg.sv ----
// Purpose: Shared constants and types of the instruction word field decoder.
// Assumes: 14-bit instruction words and a 7-bit direct register address.
// Notes: Field widths, the named codes and the counts are here; field bit positions are written out in each file.

package iwfd_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int ADDR_W = 7;
  localparam int BITPOS_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int OP_W = 4;
  localparam int FLAG_W = 3;

  // Group prefixes held in the top two bits of the word.
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_JUMP = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;

  // Byte-oriented operation codes.
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_DECSZ = 4'hB;
  localparam logic [3:0] OP_RRC = 4'hC;
  localparam logic [3:0] OP_RLC = 4'hD;
  localparam logic [3:0] OP_SWAP = 4'hE;
  localparam logic [3:0] OP_INCSZ = 4'hF;

  // Low seven bits of the miscellaneous and clear encodings.
  localparam logic [6:0] LOW_RETURN = 7'h08;
  localparam logic [6:0] LOW_RETFIE = 7'h09;
  localparam logic [6:0] LOW_SLEEP = 7'h63;
  localparam logic [6:0] LOW_CLRWDT = 7'h64;
  localparam logic [6:0] LOW_CLRACC = 7'h03;

  // Flag update mask bit positions.
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_CARRY = 1;
  localparam int FLAG_NIBBLE = 2;
  localparam logic [2:0] FLAGS_NONE = 3'h0;
  localparam logic [2:0] FLAGS_Z = 3'h1;
  localparam logic [2:0] FLAGS_C = 3'h2;
  localparam logic [2:0] FLAGS_ALL = 3'h7;

  // Register locations that steer special handling.
  localparam logic [6:0] STATUS_ADDR = 7'h03;
  localparam logic [6:0] PCL_ADDR = 7'h02;

  // Control kinds reported for literal and control words.
  localparam logic [2:0] CTL_NONE = 3'h0;
  localparam logic [2:0] CTL_CALL = 3'h1;
  localparam logic [2:0] CTL_GOTO = 3'h2;
  localparam logic [2:0] CTL_RETURN = 3'h3;
  localparam logic [2:0] CTL_RETFIE = 3'h4;
  localparam logic [2:0] CTL_RETLIT = 3'h5;
  localparam logic [2:0] CTL_SLEEP = 3'h6;
  localparam logic [2:0] CTL_CLRWDT = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int OSC_PER_CYCLE = 4;
  localparam int PHASE_W = 2;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);

  // One-hot group classification.
  typedef enum logic [2:0] {
    CLS_BYTE = 3'b001,
    CLS_BIT = 3'b010,
    CLS_LITCTL = 3'b100
  } iwfd_class_t;

  // Slot sequencer: a normal slot or the idle second cycle of a long one.
  typedef enum logic [1:0] {
    SEQ_EXEC = 2'b01,
    SEQ_FLUSH = 2'b10
  } iwfd_seq_t;

endpackage

// ---- src/iwfd_cycle_timer.sv ----
// Purpose: Divides the core clock into four-phase instruction cycles.
// Assumes: One core clock period equals one oscillator period.
// Notes: lastPhase is high in the final phase of every instruction cycle.
`timescale 1ns/1ps

module iwfd_cycle_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Phase outputs
  output logic [iwfd_pkg::PHASE_W-1:0] phase,
  output logic lastPhase
);

  logic [iwfd_pkg::PHASE_W-1:0] phase_reg;
  logic [iwfd_pkg::PHASE_W-1:0] phase_next;
  logic lastPhase_reg;
  logic lastPhase_next;

  // ----------------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------------

  // Counts the four oscillator periods of one instruction cycle.
  always_comb begin
    if (phase_reg == iwfd_pkg::PHASE_LAST) begin
      phase_next = iwfd_pkg::PHASE_RESET;
    end else begin
      phase_next = phase_reg + 2'h1;
    end
    lastPhase_next = (phase_next == iwfd_pkg::PHASE_LAST);
  end

  // Registers the counter and the last-phase marker.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= iwfd_pkg::PHASE_RESET;
      lastPhase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      lastPhase_reg <= lastPhase_next;
    end
  end

  assign phase = phase_reg;
  assign lastPhase = lastPhase_reg;

endmodule

// ---- src/iwfd_decoder.sv ----
// Purpose: Sorts 14-bit instruction words into groups and extracts operands.
// Assumes: Fetch holds a word stable while the last phase of a cycle runs.
// Notes: Decoded fields stand for one whole instruction cycle of four clocks.
`timescale 1ns/1ps

module iwfd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fetch side
  input wire logic insnValid,
  input wire logic [iwfd_pkg::WORD_W-1:0] insnWord,
  output logic insnTaken,
  // Datapath feedback
  input wire logic testTrue,
  // Timing
  output logic [iwfd_pkg::PHASE_W-1:0] phase,
  output logic lastPhase,
  // Decoded slot
  output iwfd_pkg::iwfd_class_t insnClass,
  output logic [iwfd_pkg::OP_W-1:0] opCode,
  output logic [iwfd_pkg::ADDR_W-1:0] regAddr,
  output logic destToReg,
  output logic [1:0] bitOp,
  output logic [iwfd_pkg::BITPOS_W-1:0] bitPos,
  output logic [iwfd_pkg::LIT11_W-1:0] literal,
  output logic literalWide,
  output logic [2:0] ctlKind,
  // Effects
  output logic readReg,
  output logic writeReg,
  output logic writeAcc,
  output logic [iwfd_pkg::FLAG_W-1:0] flagMask,
  output logic statusOverride,
  output logic pcChange,
  output logic condTest,
  output logic isNop,
  output logic flushSlot
);

  // Decoded values of the word on the fetch port.
  iwfd_pkg::iwfd_class_t dCls;
  logic [2:0] dCtl;
  logic [iwfd_pkg::FLAG_W-1:0] dFlags;
  logic [iwfd_pkg::LIT11_W-1:0] dLit;
  logic dWide, dRead, dWrReg, dWrAcc, dPc, dTest, dLegal, dDest, dNop;
  logic [3:0] op;
  logic [6:0] low;

  // Slot state.
  iwfd_pkg::iwfd_seq_t seq_reg, seq_next;
  logic loadWord;
  logic takeWord;

  // Output registers.
  iwfd_pkg::iwfd_class_t insnClass_reg;
  logic [iwfd_pkg::OP_W-1:0] opCode_reg;
  logic [iwfd_pkg::ADDR_W-1:0] regAddr_reg;
  logic [1:0] bitOp_reg;
  logic [iwfd_pkg::BITPOS_W-1:0] bitPos_reg;
  logic [iwfd_pkg::LIT11_W-1:0] literal_reg;
  logic [2:0] ctlKind_reg;
  logic [iwfd_pkg::FLAG_W-1:0] flagMask_reg;
  logic destToReg_reg, literalWide_reg, readReg_reg, writeReg_reg, writeAcc_reg;
  logic statusOverride_reg, pcChange_reg, condTest_reg, isNop_reg, flushSlot_reg;
  logic insnTaken_reg;

  // ----------------------------------------------------------------------
  // Cycle timing
  // ----------------------------------------------------------------------

  // Four clocks make one instruction cycle; a new slot loads after the last.
  iwfd_cycle_timer i_iwfd_cycle_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .phase(phase),
    .lastPhase(lastPhase)
  );

  // ----------------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------------

  // Splits the word into its fields and derives the effects of each encoding.
  always_comb begin
    op = insnWord[11:8];
    low = insnWord[6:0];
    dCls = iwfd_pkg::CLS_LITCTL;
    dCtl = iwfd_pkg::CTL_NONE;
    dFlags = iwfd_pkg::FLAGS_NONE;
    dLit = '0;
    dWide = 1'b0;
    dRead = 1'b0;
    dWrReg = 1'b0;
    dWrAcc = 1'b0;
    dPc = 1'b0;
    dTest = 1'b0;
    dLegal = 1'b1;
    dDest = 1'b0;
    dNop = 1'b0;
    unique case (insnWord[13:12])
      iwfd_pkg::TOP_BYTE: begin
        dCls = iwfd_pkg::CLS_BYTE;
        dDest = insnWord[7];
        if (op == iwfd_pkg::OP_MISC) begin
          if (insnWord[7]) begin
            dWrReg = 1'b1;
          end else if (insnWord[4:0] == 5'h00) begin
            dNop = 1'b1;
          end else if (low == iwfd_pkg::LOW_RETURN) begin
            dCtl = iwfd_pkg::CTL_RETURN;
          end else if (low == iwfd_pkg::LOW_RETFIE) begin
            dCtl = iwfd_pkg::CTL_RETFIE;
          end else if (low == iwfd_pkg::LOW_SLEEP) begin
            dCtl = iwfd_pkg::CTL_SLEEP;
          end else if (low == iwfd_pkg::LOW_CLRWDT) begin
            dCtl = iwfd_pkg::CTL_CLRWDT;
          end else begin
            dLegal = 1'b0;
          end
          dPc = (dCtl == iwfd_pkg::CTL_RETURN) || (dCtl == iwfd_pkg::CTL_RETFIE);
        end else if (op == iwfd_pkg::OP_CLR) begin
          dFlags = iwfd_pkg::FLAGS_Z;
          dWrReg = insnWord[7];
          dWrAcc = !insnWord[7];
          dLegal = insnWord[7] || (low == iwfd_pkg::LOW_CLRACC);
        end else begin
          dRead = 1'b1;
          dWrReg = insnWord[7];
          dWrAcc = !insnWord[7];
          dTest = (op == iwfd_pkg::OP_DECSZ) || (op == iwfd_pkg::OP_INCSZ);
          if ((op == iwfd_pkg::OP_ADD) || (op == iwfd_pkg::OP_SUB)) begin
            dFlags = iwfd_pkg::FLAGS_ALL;
          end else if ((op == iwfd_pkg::OP_RRC) || (op == iwfd_pkg::OP_RLC)) begin
            dFlags = iwfd_pkg::FLAGS_C;
          end else if (!dTest && (op != iwfd_pkg::OP_SWAP)) begin
            dFlags = iwfd_pkg::FLAGS_Z;
          end
        end
      end
      iwfd_pkg::TOP_BIT: begin
        dCls = iwfd_pkg::CLS_BIT;
        dRead = 1'b1;
        dWrReg = !insnWord[11];
        dTest = insnWord[11];
      end
      iwfd_pkg::TOP_JUMP: begin
        dLit = insnWord[10:0];
        dWide = 1'b1;
        dPc = 1'b1;
        dCtl = insnWord[11] ? iwfd_pkg::CTL_GOTO : iwfd_pkg::CTL_CALL;
      end
      iwfd_pkg::TOP_LIT: begin
        dLit = {3'h0, insnWord[7:0]};
        dWrAcc = 1'b1;
        casez (op)
          4'b111?, 4'b110?: dFlags = iwfd_pkg::FLAGS_ALL;
          4'b1000, 4'b1001, 4'b1010: dFlags = iwfd_pkg::FLAGS_Z;
          4'b00??: dFlags = iwfd_pkg::FLAGS_NONE;
          4'b01??: begin
            dCtl = iwfd_pkg::CTL_RETLIT;
            dPc = 1'b1;
          end
          default: dLegal = 1'b0;
        endcase
      end
    endcase
    // A register write aimed at the program counter low byte alters the PC.
    if (dWrReg && (low == iwfd_pkg::PCL_ADDR)) begin
      dPc = 1'b1;
    end
    // Undefined encodings lose every effect.
    if (!dLegal) begin
      dCtl = iwfd_pkg::CTL_NONE;
      dFlags = iwfd_pkg::FLAGS_NONE;
      dRead = 1'b0;
      dWrReg = 1'b0;
      dWrAcc = 1'b0;
      dPc = 1'b0;
      dTest = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Slot sequencing
  // ----------------------------------------------------------------------

  // At each cycle end, a taken test or PC change turns the next slot into a no-op.
  always_comb begin
    seq_next = seq_reg;
    if (lastPhase) begin
      if (seq_reg == iwfd_pkg::SEQ_EXEC && (pcChange_reg || (condTest_reg && testTrue))) begin
        seq_next = iwfd_pkg::SEQ_FLUSH;
      end else begin
        seq_next = iwfd_pkg::SEQ_EXEC;
      end
    end
    loadWord = lastPhase;
    takeWord = lastPhase && (seq_next == iwfd_pkg::SEQ_EXEC) && insnValid;
  end

  // Holds the slot state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_reg <= iwfd_pkg::SEQ_EXEC;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // ----------------------------------------------------------------------
  // Decoded slot registers
  // ----------------------------------------------------------------------

  // Loads a decoded word, or a bubble, and holds it for the whole cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      insnClass_reg <= iwfd_pkg::CLS_BYTE;
      opCode_reg <= '0;
      regAddr_reg <= '0;
      destToReg_reg <= 1'b0;
      bitOp_reg <= '0;
      bitPos_reg <= '0;
      literal_reg <= '0;
      literalWide_reg <= 1'b0;
      ctlKind_reg <= iwfd_pkg::CTL_NONE;
      readReg_reg <= 1'b0;
      writeReg_reg <= 1'b0;
      writeAcc_reg <= 1'b0;
      flagMask_reg <= iwfd_pkg::FLAGS_NONE;
      statusOverride_reg <= 1'b0;
      pcChange_reg <= 1'b0;
      condTest_reg <= 1'b0;
      isNop_reg <= 1'b1;
      flushSlot_reg <= 1'b0;
      insnTaken_reg <= 1'b0;
    end else begin
      insnTaken_reg <= takeWord;
      if (loadWord) begin
        flushSlot_reg <= (seq_next == iwfd_pkg::SEQ_FLUSH);
        insnClass_reg <= takeWord ? dCls : iwfd_pkg::CLS_BYTE;
        opCode_reg <= takeWord ? op : iwfd_pkg::OP_MISC;
        regAddr_reg <= takeWord ? low : 7'h00;
        destToReg_reg <= takeWord && dDest;
        bitOp_reg <= takeWord ? insnWord[11:10] : 2'h0;
        bitPos_reg <= takeWord ? insnWord[9:7] : 3'h0;
        literal_reg <= takeWord ? dLit : '0;
        literalWide_reg <= takeWord && dWide;
        ctlKind_reg <= takeWord ? dCtl : iwfd_pkg::CTL_NONE;
        readReg_reg <= takeWord && dRead;
        writeReg_reg <= takeWord && dWrReg;
        writeAcc_reg <= takeWord && dWrAcc;
        flagMask_reg <= takeWord ? dFlags : iwfd_pkg::FLAGS_NONE;
        statusOverride_reg <= takeWord && dWrReg && (low == iwfd_pkg::STATUS_ADDR)
          && (dFlags != iwfd_pkg::FLAGS_NONE);
        pcChange_reg <= takeWord && dPc;
        condTest_reg <= takeWord && dTest;
        isNop_reg <= !takeWord || !dLegal || dNop;
      end
    end
  end

  assign insnTaken = insnTaken_reg;
  assign insnClass = insnClass_reg;
  assign opCode = opCode_reg;
  assign regAddr = regAddr_reg;
  assign destToReg = destToReg_reg;
  assign bitOp = bitOp_reg;
  assign bitPos = bitPos_reg;
  assign literal = literal_reg;
  assign literalWide = literalWide_reg;
  assign ctlKind = ctlKind_reg;
  assign readReg = readReg_reg;
  assign writeReg = writeReg_reg;
  assign writeAcc = writeAcc_reg;
  assign flagMask = flagMask_reg;
  assign statusOverride = statusOverride_reg;
  assign pcChange = pcChange_reg;
  assign condTest = condTest_reg;
  assign isNop = isNop_reg;
  assign flushSlot = flushSlot_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  property p_class_onehot;
    @(posedge clk) disable iff (sys_rst) $onehot(insnClass_reg);
  endproperty
  a_class_onehot: assert property (p_class_onehot) else $error("Class not one-hot.");

  property p_byte_layout;
    @(posedge clk) disable iff (sys_rst)
      takeWord && (insnWord[13:12] == 2'h0) |=> (insnClass_reg == iwfd_pkg::CLS_BYTE)
      && (regAddr_reg == $past(insnWord[6:0])) && (destToReg_reg == $past(insnWord[7]));
  endproperty
  a_byte_layout: assert property (p_byte_layout) else $error("Byte fields wrong.");

  property p_target;
    @(posedge clk) disable iff (sys_rst)
      insnTaken_reg && readReg_reg && (insnClass_reg == iwfd_pkg::CLS_BYTE)
      |-> (writeReg_reg == destToReg_reg) && (writeAcc_reg == !destToReg_reg);
  endproperty
  a_target: assert property (p_target) else $error("Result target wrong.");

  property p_bit_fields;
    @(posedge clk) disable iff (sys_rst)
      takeWord && (insnWord[13:12] == 2'h1) |=> (insnClass_reg == iwfd_pkg::CLS_BIT)
      && (bitPos_reg == $past(insnWord[9:7])) && (bitOp_reg == $past(insnWord[11:10]));
  endproperty
  a_bit_fields: assert property (p_bit_fields) else $error("Bit fields wrong.");

  property p_rmw;
    @(posedge clk) disable iff (sys_rst)
      insnTaken_reg && (insnClass_reg == iwfd_pkg::CLS_BIT) && !bitOp_reg[1]
      |-> readReg_reg && writeReg_reg;
  endproperty
  a_rmw: assert property (p_rmw) else $error("Bit change not read-modify-write.");

  property p_literal;
    @(posedge clk) disable iff (sys_rst)
      takeWord && insnWord[13] |=> (literalWide_reg == !$past(insnWord[12]))
      && (literal_reg[7:0] == $past(insnWord[7:0]));
  endproperty
  a_literal: assert property (p_literal) else $error("Literal wrong.");

  property p_nop_dontcare;
    @(posedge clk) disable iff (sys_rst)
      takeWord && (insnWord[13:7] == 7'h00) && (insnWord[4:0] == 5'h00) |=> isNop_reg;
  endproperty
  a_nop_dontcare: assert property (p_nop_dontcare) else $error("Don't-care bits used.");

  property p_cycle_len;
    @(posedge clk) disable iff (sys_rst) lastPhase |=> !lastPhase [*3] ##1 lastPhase;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("Cycle not four clocks.");

  property p_second_cycle;
    @(posedge clk) disable iff (sys_rst)
      lastPhase && !flushSlot_reg && (pcChange_reg || (condTest_reg && testTrue))
      |=> (flushSlot_reg && isNop_reg && !insnTaken_reg) [*4];
  endproperty
  a_second_cycle: assert property (p_second_cycle) else $error("No idle second cycle.");

  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      !lastPhase |=> $stable(regAddr_reg) && $stable(insnClass_reg) && $stable(literal_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("Fields moved mid-cycle.");

  property p_undefined;
    @(posedge clk) disable iff (sys_rst)
      isNop_reg |-> !writeReg_reg && !writeAcc_reg && !pcChange_reg && !condTest_reg
      && (flagMask_reg == iwfd_pkg::FLAGS_NONE);
  endproperty
  a_undefined: assert property (p_undefined) else $error("No-op has effects.");

  property p_status;
    @(posedge clk) disable iff (sys_rst)
      statusOverride_reg |-> writeReg_reg && (regAddr_reg == iwfd_pkg::STATUS_ADDR)
      && (flagMask_reg != iwfd_pkg::FLAGS_NONE);
  endproperty
  a_status: assert property (p_status) else $error("Flag override wrong.");

  property p_word_split;
    @(posedge clk) disable iff (sys_rst) takeWord |=> opCode_reg == $past(insnWord[11:8]);
  endproperty
  a_word_split: assert property (p_word_split) else $error("Opcode field wrong.");

  property p_addr_range;
    @(posedge clk) disable iff (sys_rst)
      takeWord && !insnWord[13] |=> regAddr_reg == $past(insnWord[6:0]);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("Address wrong.");

endmodule

// ---- verification/iwfd_fetch_model.sv ----
// Purpose: Program memory fetch partner that presents one word per instruction cycle.
// Assumes: The decoder samples the word at the edge that ends phase 3.
// Notes: Outside its hold window the word is scrambled so stale values never pass.
`timescale 1ns/1ps

module iwfd_fetch_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bench control
  input wire logic [1:0] phase,
  input wire logic [13:0] wantWord,
  input wire logic wantValid,
  // Fetch side
  output logic insnValid,
  output logic [13:0] insnWord
);
  // --------------------------------------------------------------------
  // Word presentation
  // --------------------------------------------------------------------
  // Load in phase 2 so the word is steady over the phase 3 sampling edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      insnValid <= 1'b0;
      insnWord <= 14'h0000;
    end else if (phase == 2'h2) begin
      insnValid <= wantValid;
      insnWord <= wantValid ? wantWord : ~insnWord;
    end else if (phase == 2'h0) begin
      insnValid <= 1'b0;
      insnWord <= ~insnWord;
    end
  end
endmodule

// ---- verification/insn_word_field_decoder_test.sv ----
// Purpose: Self-checking bench for the instruction word field decoder.
// Assumes: One instruction cycle is four clocks and fields show in phase 0.
// Notes: Corner words come first, then repeatable random words and bubbles.
`timescale 1ns/1ps

module insn_word_field_decoder_test;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic testTrue = 1'b0;
  logic [13:0] wantWord = 14'h0000;
  logic wantValid = 1'b0;
  logic insnValid, insnTaken, lastPhase, destToReg, literalWide, readReg, writeReg;
  logic writeAcc, statusOverride, pcChange, condTest, isNop, flushSlot;
  logic [13:0] insnWord;
  logic [1:0] phase, bitOp;
  logic [3:0] opCode;
  logic [2:0] ctlKind;
  logic [2:0] bitPos, flagMask;
  logic [6:0] regAddr;
  logic [10:0] literal;
  iwfd_pkg::iwfd_class_t insnClass;
  int errTotal = 0;
  int totalChecks = 0;
  int seed = 32'h5bc5;
  logic pcPrev = 1'b0;
  logic cdPrev = 1'b0;

  // The clock toggles every half period of 2 ns.
  always #2 clk = ~clk;

  iwfd_fetch_model i_iwfd_fetch_model (.clk(clk), .sys_rst(sys_rst), .phase(phase),
    .wantWord(wantWord), .wantValid(wantValid), .insnValid(insnValid), .insnWord(insnWord));

  iwfd_decoder i_iwfd_decoder (.clk(clk), .sys_rst(sys_rst), .insnValid(insnValid),
    .insnWord(insnWord), .insnTaken(insnTaken), .testTrue(testTrue), .phase(phase),
    .lastPhase(lastPhase), .insnClass(insnClass), .opCode(opCode), .regAddr(regAddr),
    .destToReg(destToReg), .bitOp(bitOp), .bitPos(bitPos), .literal(literal),
    .literalWide(literalWide), .ctlKind(ctlKind), .readReg(readReg), .writeReg(writeReg),
    .writeAcc(writeAcc), .flagMask(flagMask), .statusOverride(statusOverride),
    .pcChange(pcChange), .condTest(condTest), .isNop(isNop), .flushSlot(flushSlot));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Compares one observation and counts it.
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("errors %0d checks %0d", errTotal, totalChecks);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Expected slot fields of a taken word, packed like the observed vector.
  function automatic logic [34:0] expv(input logic [13:0] w);
    logic [2:0] c;
    logic [10:0] k;
    logic pc, cd, np, wr, wa;
    logic [3:0] op;
    op = w[11:8];
    c = 3'b100;
    k = 11'h000;
    {pc, cd, np, wr, wa} = 5'h00;
    case (w[13:12])
      2'h0: begin
        c = 3'b001;
        wr = w[7];
        wa = !w[7];
        cd = (op == 4'hB) || (op == 4'hF);
        if (op == 4'h0 && !w[7]) begin
          wa = 1'b0;
          pc = (w[6:0] == 7'h08) || (w[6:0] == 7'h09);
          np = !(pc || w[6:0] == 7'h63 || w[6:0] == 7'h64);
        end
        if (op == 4'h1 && !w[7]) begin
          wa = (w[6:0] == 7'h03);
          np = !wa;
        end
        pc = pc || (wr && w[6:0] == 7'h02);
      end
      2'h1: begin
        c = 3'b010;
        wr = !w[11];
        cd = w[11];
        pc = wr && (w[6:0] == 7'h02);
      end
      2'h2: begin
        k = w[10:0];
        pc = 1'b1;
      end
      default: begin
        k = {3'h0, w[7:0]};
        np = (op == 4'hB);
        wa = !np;
        pc = !np && (w[11:10] == 2'h1);
      end
    endcase
    return {c, w[6:0], (w[13:12] == 2'h0) & w[7], (c == 3'b010) ? w[11:7] : 5'h00, k,
      w[13:12] == 2'h2, pc, cd, np, 2'b10, wr, wa};
  endfunction

  // Expected opcode, control kind, flag mask and register read of a taken word.
  function automatic logic [34:0] expk(input logic [13:0] w);
    logic [3:0] op;
    logic [2:0] ck;
    logic [2:0] fm;
    logic rd;
    op = w[11:8];
    {ck, fm, rd} = 7'h00;
    case (w[13:12])
      2'h0: begin
        rd = (op > 4'h1);
        if (op == 4'h2 || op == 4'h7) fm = 3'h7;
        else if (op == 4'hC || op == 4'hD) fm = 3'h2;
        else if (op > 4'h2 && op != 4'hB && op < 4'hE) fm = 3'h1;
        else if (op == 4'h1 && (w[7] || w[6:0] == 7'h03)) fm = 3'h1;
        if (op == 4'h0 && !w[7]) begin
          case (w[6:0])
            7'h08: ck = 3'h3;
            7'h09: ck = 3'h4;
            7'h63: ck = 3'h6;
            7'h64: ck = 3'h7;
            default: ck = 3'h0;
          endcase
        end
      end
      2'h1: rd = 1'b1;
      2'h2: ck = w[11] ? 3'h2 : 3'h1;
      default: begin
        if (op[3:2] == 2'b01) ck = 3'h5;
        else if (op[3:2] == 2'b11) fm = 3'h7;
        else if (op == 4'h8 || op == 4'h9 || op == 4'hA) fm = 3'h1;
      end
    endcase
    return {24'h000000, op, ck, fm, rd};
  endfunction

  // Presents one word over the next sampling edge and waits for its slot.
  task automatic issue(input logic [13:0] w, input logic v, input logic t);
    do @(negedge clk); while (phase !== 2'h1);
    @(posedge clk);
    wantWord <= w;
    wantValid <= v;
    testTrue <= t;
    repeat (2) @(negedge clk);
    check({phase, lastPhase}, 35'h7);
    @(negedge clk);
  endtask

  // Runs one word, including the idle cycle that a prior branch or taken test costs.
  task automatic slot(input logic [13:0] w, input logic v);
    logic t;
    logic fl;
    logic [34:0] e;
    t = 1'($random(seed));
    fl = pcPrev || (cdPrev && t);
    e = expv(w);
    issue(w, v, t);
    if (fl) begin
      check({insnTaken, isNop, flushSlot}, 35'h3);
      issue(w, v, t);
    end
    if (!v) begin
      check({insnTaken, isNop, flushSlot}, 35'h2);
      {pcPrev, cdPrev} = 2'b00;
    end else begin
      check({insnClass, regAddr, destToReg,
        (w[13:12] == 2'h1) ? {bitOp, bitPos} : 5'h00, literal, literalWide,
        pcChange, condTest, isNop, insnTaken, flushSlot, writeReg, writeAcc},
        e);
      check({24'h000000, opCode, ctlKind, flagMask, readReg}, expk(w));
      pcPrev = e[6];
      cdPrev = e[5];
      if (w === 14'h0183) check({statusOverride, flagMask}, 35'h9);
      if (w[13:11] === 3'b010) check({readReg, writeReg}, 35'h3);
    end
  endtask

  // --------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------
  // Resets, runs the corner words, then random words with bubbles.
  initial begin
    logic [13:0] w;
    static logic [13:0] corner [18] = '{14'h0060, 14'h0000, 14'h0008, 14'h0009, 14'h0063,
      14'h0064, 14'h0062, 14'h0103, 14'h0104, 14'h3B55, 14'h0183, 14'h0082, 14'h1502,
      14'h1D7F, 14'h2FFF, 14'h2000, 14'h3400, 14'h3C7F};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (corner[i]) slot(corner[i], 1'b1);
    for (int n = 0; n < 300; n++) begin
      w = 14'($random(seed));
      if (w[13:9] == 5'h00) w[7] = 1'b1;
      if (w[13:8] == 6'h3B) w[8] = 1'b0;
      slot(w, ($random(seed) & 7) != 0);
    end
    results;
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    results;
  end
endmodule
